// *** rtl/period_meter.sv ***
`timescale 1ns/1ps
`include "speed_mon_defs.svh"
// Measures rising-edge spacing of one signal in clock cycles
module period_meter #(
  parameter int CW = `CNT_W
) (
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          rst_b,
  input  wire logic          ce,
  // Signal
  input  wire logic          sig,
  // Result
  output logic [CW-1:0]      period_r,
  output logic               edge_r
);
  logic          sig_d_r;
  logic          armed_r;
  logic [CW-1:0] cnt_r;
  logic          rise;

  // No edge until the delay holds a real level; a high pin at reset
  // would otherwise read as a rise
  assign rise = sig & ~sig_d_r & armed_r;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sig_d_r <= 1'b0;
      armed_r <= 1'b0;
    end else if (ce) begin
      sig_d_r <= sig;
      armed_r <= 1'b1;
    end
  end

  // Saturating age counter; a missing edge reads as a long period
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r    <= CW'(`CNT_ZERO);
      period_r <= CW'(`CNT_MAX);
      edge_r   <= `FLAG_RESET;
    end else if (ce) begin
      edge_r <= rise;
      if (rise) begin
        period_r <= cnt_r;
        cnt_r    <= CW'(`CNT_ONE);
      end else begin
        if (cnt_r != CW'(`CNT_MAX))
          cnt_r <= cnt_r + CW'(1);
        if (cnt_r > period_r)
          period_r <= cnt_r;
      end
    end
  end
endmodule

// *** rtl/speed_mon.sv ***
`timescale 1ns/1ps
`include "speed_mon_defs.svh"
// Behaviour
// - With encoder plus proximity switch, track A, track B and the switch are each measured separately.
// - In that mixed mode standstill needs at least two of the three signals below standstill frequency.
// - Shearpin break is flagged when both tracks are still while the switch shows rotation.
// - A shearpin break forces the safe state only when its option is enabled.
// - Two axes are monitored independently with their own inputs, evaluations and status.
// - Eight speed thresholds are held and the selected one is compared to report excess speed.
module speed_mon #(
  parameter int AXES = 2,
  parameter int CW   = `CNT_W,
  parameter int NT   = `NUM_THRESH
) (
  // Clock and reset
  input  wire logic                      clk,
  input  wire logic                      rst_b,
  input  wire logic                      ce,
  // Sensor inputs per axis
  input  speed_mon_pkg::axis_inputs_t    sens     [AXES],
  // Configuration per axis
  input  speed_mon_pkg::axis_mode_t      mode     [AXES],
  input  wire logic                      shear_en [AXES],
  input  wire logic [CW-1:0]             still_per[AXES],
  input  wire logic [CW-1:0]             thresh   [AXES][NT],
  input  wire logic [`SEL_W-1:0]         sel      [AXES],
  // Status to base unit
  output speed_mon_pkg::axis_status_t    status_r [AXES]
);
  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  // Period longer than the standstill period means below frequency
  function automatic logic is_slow(input logic [CW-1:0] p,
                                   input logic [CW-1:0] lim);
    is_slow = (p > lim);
  endfunction

  function automatic logic vote2(input logic a, input logic b,
                                 input logic c);
    vote2 = (a & b) | (a & c) | (b & c);
  endfunction

  // ------------------------------------------------------------
  // Per-axis evaluation
  // ------------------------------------------------------------
  for (genvar ax = 0; ax < AXES; ax++) begin : g_axis
    logic [CW-1:0] per_a, per_b, per_p, per_q;
    logic          edg_a, edg_b, edg_p, edg_q;
    logic          slow_a, slow_b, slow_p, slow_q;
    logic          still, shear, fast, dir_nxt;
    logic [CW-1:0] enc_per, lim;

    period_meter #(.CW(CW)) u_a (
      .clk(clk), .rst_b(rst_b), .ce(ce), .sig(sens[ax].track_a),
      .period_r(per_a), .edge_r(edg_a));
    period_meter #(.CW(CW)) u_b (
      .clk(clk), .rst_b(rst_b), .ce(ce), .sig(sens[ax].track_b),
      .period_r(per_b), .edge_r(edg_b));
    period_meter #(.CW(CW)) u_p (
      .clk(clk), .rst_b(rst_b), .ce(ce), .sig(sens[ax].prox),
      .period_r(per_p), .edge_r(edg_p));
    period_meter #(.CW(CW)) u_q (
      .clk(clk), .rst_b(rst_b), .ce(ce), .sig(sens[ax].prox2),
      .period_r(per_q), .edge_r(edg_q));

    assign slow_a = is_slow(per_a, still_per[ax]);
    assign slow_b = is_slow(per_b, still_per[ax]);
    assign slow_p = is_slow(per_p, still_per[ax]);
    assign slow_q = is_slow(per_q, still_per[ax]);

    always_comb begin
      still   = 1'b0;
      shear   = 1'b0;
      enc_per = per_a;
      case (mode[ax])
        speed_mon_pkg::MODE_ENCODER: begin
          still = slow_a & slow_b;
        end
        speed_mon_pkg::MODE_PROX_PAIR: begin
          still   = slow_p & slow_q;
          enc_per = per_p;
        end
        speed_mon_pkg::MODE_ENC_PROX: begin
          still = vote2(slow_a, slow_b, slow_p);
          shear = slow_a & slow_b & ~slow_p;
        end
        default: begin
          still = 1'b0;
        end
      endcase
    end

    // Fewer cycles per edge than the selected limit is too fast
    assign lim  = thresh[ax][sel[ax]];
    assign fast = ~still & (enc_per < lim);

    // Direction: B level one cycle after the A rise; high is forward
    assign dir_nxt = sens[ax].track_b;

    // Status outputs refresh every enabled cycle, except direction, which updates only on an A edge
    always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
        status_r[ax] <= '0;
      end else if (ce) begin
        status_r[ax].standstill      <= still;
        status_r[ax].excess_speed    <= fast;
        status_r[ax].shearpin_broken <= shear;
        status_r[ax].safe_state      <= fast | (shear & shear_en[ax]);
        if (edg_a)
          status_r[ax].direction <= dir_nxt;
      end
    end
  end
endmodule

// *** rtl/speed_mon_defs.svh ***
`ifndef SPEED_MON_DEFS_SVH
`define SPEED_MON_DEFS_SVH
`define CNT_W        24
`define CNT_ZERO     24'h000000
`define CNT_ONE      24'h000001
`define CNT_MAX      24'hFFFFFF
`define FLAG_RESET   1'b0
`define NUM_THRESH   8
`define SEL_W        3
`endif

// *** rtl/speed_mon_pkg.sv ***
package speed_mon_pkg;
  typedef enum logic [1:0] {
    MODE_ENCODER,
    MODE_PROX_PAIR,
    MODE_ENC_PROX
  } axis_mode_t;

  typedef struct packed {
    logic standstill;
    logic excess_speed;
    logic shearpin_broken;
    logic safe_state;
    logic direction;
  } axis_status_t;

  typedef struct packed {
    logic track_a;
    logic track_b;
    logic prox;
    logic prox2;
  } axis_inputs_t;
endpackage

// *** tb/shaft_model.sv ***
`timescale 1ns/1ps
// Shaft with encoder and switch; a half period of 0 holds it still
module shaft_model (
  input  wire logic                   clk,
  input  wire logic [7:0]             enc_half,
  input  wire logic [7:0]             prox_half,
  output speed_mon_pkg::axis_inputs_t sig
);
  logic [7:0] ecnt = 8'h00;
  logic [7:0] pcnt = 8'h00;
  logic [1:0] q    = 2'h0;
  logic       p    = 1'b0;
  always @(negedge clk) begin
    ecnt <= (ecnt + 8'h01 == enc_half) ? 8'h00 : ecnt + 8'h01;
    if (enc_half != 8'h00 && ecnt + 8'h01 == enc_half) q <= q + 2'h1;
    pcnt <= (pcnt + 8'h01 == prox_half) ? 8'h00 : pcnt + 8'h01;
    if (prox_half != 8'h00 && pcnt + 8'h01 == prox_half) p <= ~p;
  end
  // Gray count gives the quarter-period offset between the tracks
  assign sig = {q[1], q[1] ^ q[0], p, 1'b0};
endmodule

// *** tb/speed_mon_chk.sv ***
`timescale 1ns/1ps
module speed_mon_chk #(
  parameter int AXES = 2
) (
  input wire logic                   clk,
  input wire logic                   rst_b,
  input wire logic                   ce,
  input speed_mon_pkg::axis_mode_t   mode     [AXES],
  input wire logic                   shear_en [AXES],
  input speed_mon_pkg::axis_status_t status_r [AXES]
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  chk_shear_mode_only:
    assert property (status_r[0].shearpin_broken |->
      mode[0] == speed_mon_pkg::MODE_ENC_PROX) else $error("shear mode");
  chk_shear_vote:
    assert property (status_r[0].shearpin_broken |-> status_r[0].standstill)
      else $error("shear without vote");
  chk_safe_gate:
    assert property ($stable(shear_en[0]) |-> status_r[0].safe_state ==
      (status_r[0].excess_speed | (status_r[0].shearpin_broken & shear_en[0])))
      else $error("safe state");
  chk_axis1_apart:
    assert property (status_r[1].standstill |-> !status_r[1].excess_speed)
      else $error("axis1 excess");
  chk_axis1_shear:
    assert property (status_r[1].shearpin_broken |-> status_r[1].standstill)
      else $error("axis1 shear");
  chk_still_no_exc:
    assert property (status_r[0].standstill |-> !status_r[0].excess_speed)
      else $error("excess at standstill");
  chk_freeze_hold:
    assert property (!ce |=> $stable(status_r[0])) else $error("not frozen");
  cover property (status_r[0].shearpin_broken && status_r[0].safe_state);
  cover property (status_r[0].excess_speed);
  cover property ($fell(status_r[0].standstill));
endmodule
bind speed_mon speed_mon_chk #(.AXES(AXES)) chk_u (.clk(clk), .rst_b(rst_b),
  .ce(ce), .mode(mode), .shear_en(shear_en), .status_r(status_r));

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  logic                         clk   = 1'b0;
  logic                         rst_b = 1'b0;
  logic                         ce    = 1'b1;
  logic [7:0]                   enc_half = 8'h00;
  logic [7:0]                   prox_half = 8'h00;
  speed_mon_pkg::axis_inputs_t  sens [2];
  speed_mon_pkg::axis_mode_t    mode [2];
  logic                         shear_en [2];
  logic [23:0]                  still_per [2];
  logic [23:0]                  thresh [2][8];
  logic [2:0]                   sel [2];
  speed_mon_pkg::axis_status_t  status_r [2];
  int                           error_cnt = 0;
  int                           comparisons = 0;
  always #12.5 clk = ~clk;
  shaft_model sh0_u (.clk(clk), .enc_half(enc_half),
    .prox_half(prox_half), .sig(sens[0]));
  // Axis 1 always turns, so any coupling from axis 0 shows there
  shaft_model sh1_u (.clk(clk), .enc_half(8'h02), .prox_half(8'h03),
    .sig(sens[1]));
  speed_mon #(.AXES(2), .CW(24), .NT(8)) dut_u (.clk(clk), .rst_b(rst_b),
    .ce(ce), .sens(sens), .mode(mode), .shear_en(shear_en),
    .still_per(still_per), .thresh(thresh), .sel(sel), .status_r(status_r));
  task automatic compare5(input string what, input logic [4:0] exp, got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic stop_test();
    if (error_cnt == 0 && comparisons > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Expected bits: standstill, excess, shearpin, safe state, direction
  task automatic run_case(input speed_mon_pkg::axis_mode_t m,
    input logic [7:0] e, p, input logic sh, input logic [2:0] s,
    input logic [3:0] exp);
    @(negedge clk);
    rst_b = 1'b0;
    mode[0] = m;
    enc_half = e;
    prox_half = p;
    shear_en[0] = sh;
    sel[0] = s;
    repeat (10) @(negedge clk);
    rst_b = 1'b1;
    ce = 1'b0;
    repeat (3) @(negedge clk);
    ce = 1'b1;
    repeat (200) @(negedge clk);
    compare5("axis0", {exp, e != 8'h00}, {status_r[0].standstill,
      status_r[0].excess_speed, status_r[0].shearpin_broken,
      status_r[0].safe_state, status_r[0].direction});
    compare5("axis1", 5'h01, {status_r[1].standstill,
      status_r[1].excess_speed, status_r[1].shearpin_broken,
      status_r[1].safe_state, status_r[1].direction});
  endtask
  task automatic mixed_vote();
    run_case(speed_mon_pkg::MODE_ENC_PROX, 8'h00, 8'h00, 1, 0, 4'h8);
    run_case(speed_mon_pkg::MODE_ENC_PROX, 8'h02, 8'h03, 1, 0, 4'h0);
    run_case(speed_mon_pkg::MODE_ENC_PROX, 8'h02, 8'h00, 1, 0, 4'h0);
  endtask
  task automatic shearpin();
    run_case(speed_mon_pkg::MODE_ENC_PROX, 8'h00, 8'h03, 1, 0, 4'hB);
    run_case(speed_mon_pkg::MODE_ENC_PROX, 8'h00, 8'h03, 0, 0, 4'hA);
  endtask
  task automatic overspeed();
    run_case(speed_mon_pkg::MODE_ENCODER, 8'h02, 8'h00, 0, 2, 4'h0);
    run_case(speed_mon_pkg::MODE_ENCODER, 8'h02, 8'h00, 0, 3, 4'h5);
    run_case(speed_mon_pkg::MODE_PROX_PAIR, 8'h00, 8'h00, 0, 7, 4'h8);
  endtask
  initial begin
    for (int a = 0; a < 2; a++) begin
      still_per[a] = 24'h000014;
      for (int k = 0; k < 8; k++) thresh[a][k] = 24'(k * 4);
    end
    mode = '{speed_mon_pkg::MODE_ENC_PROX, speed_mon_pkg::MODE_ENC_PROX};
    shear_en = '{1'b0, 1'b1};
    sel = '{3'h0, 3'h0};
    mixed_vote();
    shearpin();
    overspeed();
    stop_test();
  end
endmodule
